// ==== rtl/flash_prot_cob.sv ====
// flash protection registers, data flash protection checker and command object array
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// block overview:
// holds the two add-only protection registers of the flash controller
// checks each engine program or erase against the data flash window
// owns the six-word command object that software fills before launch
// software writes to the object and both protection registers are refused while busy
// the configuration bytes arrive on ports and load once after reset
// nothing here runs a command; the engine outside does that
//
// register map on the plain port, low byte used unless noted:
//   0 program flash protection, 1 data flash protection
//   2 object index, 3 object high byte, 4 object low byte
//   5 status, 6 reserved zero, 7 object word (all sixteen bits)
//
// status layout: bit 7 complete flag, bit 4 violation flag
//   writing one to bit 7 while idle launches a command
//   writing one to bit 4 clears the violation flag
//
// limitations: no error signal on refused writes, software must
// read back; index writes are never locked, only the words are

// Contract
// - pflash protection follows allowed scenario transitions only
// - disallowed pflash scenario write is fully discarded
// - pflash protection read shows scenario in force
// - dflash size field only grows
// - dflash open bit only goes one to zero
// - dflash open bit zero protects, one unprotects
// - open bit one makes size field irrelevant
// - dflash protection loaded from configuration byte
// - double fault at load means full protection
// - protected program/erase refused, violation flag set
// - block erase refused if any sector protected
// - range from base, (size+1) times 256 bytes
// - six 16-bit words, byte and word access
// - object locked while command runs
// - results land in object, read after completion
// - indices six and seven read zero, ignore writes
// - word zero high code, low zero plus address
// - reserved register reads zero, ignores writes
// - high size writable only while high disable set
// - low size writable only while low disable set
module flash_prot_cob (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire flash_prot_pkg::reg_req_t req_in,
    output logic [15:0] rdata_out,
    // configuration bytes sampled at the first edge after reset release
    input wire logic [7:0] cfg_pprot_in,
    input wire logic [7:0] cfg_dprot_in,
    input wire logic cfg_dbl_fault_in,
    // command engine side
    input wire flash_prot_pkg::chk_req_t chk_in,
    input wire logic done_in,
    input wire logic res_we_in,
    input wire logic [2:0] res_idx_in,
    input wire logic [15:0] res_data_in,
    output logic launch_out,
    output logic refuse_out,
    output logic busy_out,
    output logic [15:0] cob_word0_out,
    output logic [15:0] cob_word1_out
);

    // program flash protection, scenario bits plus size fields
    logic [7:0] pprot_r;
    // data flash protection, open bit plus size field
    logic [7:0] dprot_r;
    // object index, three bits reach all eight codes
    logic [2:0] cidx_r;
    // object words; codes six and seven have no storage
    logic [15:0] cob_r [flash_prot_pkg::COB_WORDS];
    // command complete flag and its registered inverse for the port
    logic command_complete_flag_r;
    logic busy_r;
    // sticky violation flag
    logic pviol_r;
    // low for the single load cycle after reset release
    logic loaded_r;
    // registered outputs
    logic [15:0] rdata_r;
    logic launch_r;
    logic refuse_r;

    // scenario is open, high disable, low disable packed in that order
    function automatic logic [2:0] scen(input logic [7:0] v);
        scen = {v[flash_prot_pkg::PP_OPEN], v[flash_prot_pkg::PP_HDIS], v[flash_prot_pkg::PP_LDIS]};
    endfunction : scen

    // transition table: bit t of row f set when f may move to t
    // rows only allow adding protection; scenario three is a dead end
    // scenario seven reaches everything, so it is the factory default
    function automatic logic trans_ok(input logic [2:0] f, input logic [2:0] t);
        logic [7:0] row;
        row = 8'h00;
        unique case (f)
            3'h0: row = 8'h0f;
            3'h1: row = 8'h0a;
            3'h2: row = 8'h0c;
            3'h3: row = 8'h08;
            3'h4: row = 8'h18;
            3'h5: row = 8'h3c;
            3'h6: row = 8'h5a;
            3'h7: row = 8'hff;
        endcase
        trans_ok = row[t];
    endfunction : trans_ok

    // protected byte count end address: base + (size+1)*256
    // one past the last protected byte, so the compare is a plain less-than
    // size zero still protects one sector of 256 bytes
    function automatic logic [22:0] df_end(input logic [4:0] sz);
        df_end = flash_prot_pkg::DF_BASE + 23'({18'h0, sz} + 23'h1) * (23'h1 << flash_prot_pkg::DF_SECT_SHIFT);
    endfunction : df_end


    // register port decode for the protection bytes
    // only the low byte of the write data matters for byte registers
    // the reserved bit six is masked off before any compare
    logic wr_pp;
    logic wr_dp;
    logic [7:0] pp_cand;
    logic [7:0] wb;
    always_comb begin
        wb = req_in.wdata[7:0];
        wr_pp = req_in.wr && req_in.addr == flash_prot_pkg::OFS_PPROT;
        wr_dp = req_in.wr && req_in.addr == flash_prot_pkg::OFS_DPROT;
        // size fields only take the written value while their disable bit is set now
        pp_cand = wb & flash_prot_pkg::PP_WMASK;
        if (!pprot_r[flash_prot_pkg::PP_HDIS]) begin
            pp_cand[flash_prot_pkg::PP_HS_LSB +: 2] = pprot_r[flash_prot_pkg::PP_HS_LSB +: 2];
        end
        if (!pprot_r[flash_prot_pkg::PP_LDIS]) begin
            pp_cand[flash_prot_pkg::PP_LS_LSB +: 2] = pprot_r[flash_prot_pkg::PP_LS_LSB +: 2];
        end
    end


    // reset tracking: load happens at first edge after release so no port feeds a reset value
    // the load cycle also blocks a protection register write at that same edge
    // so software must wait one edge after release before its first access
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
        end
    end


    // program flash protection register
    // a write needs the idle flag and an allowed transition, else it is dropped whole
    // double fault leaves the open bit clear and the other used bits set
    // the reserved bit is masked at load too, so it always reads zero
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pprot_r <= 8'h00;
        end else if (!loaded_r) begin
            pprot_r <= (cfg_dbl_fault_in ? 8'h7f : cfg_pprot_in) & flash_prot_pkg::PP_WMASK;
        end else if (wr_pp && command_complete_flag_r && trans_ok(scen(pprot_r), scen(pp_cand))) begin
            pprot_r <= pp_cand;
        end
    end


    // data flash protection register: add-only
    // size grows, open bit only falls; each field is judged on its own
    // so one write may tighten one field and be ignored for the other
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            dprot_r <= 8'h00;
        end else if (!loaded_r) begin
            if (cfg_dbl_fault_in) begin
                dprot_r <= {1'b0, 2'b00, flash_prot_pkg::DP_SIZE_FULL};
            end else begin
                dprot_r <= cfg_dprot_in & flash_prot_pkg::DP_WMASK;
            end
        end else if (wr_dp && command_complete_flag_r) begin
            if (wb[4:0] > dprot_r[4:0]) begin
                dprot_r[4:0] <= wb[4:0];
            end
            if (!wb[flash_prot_pkg::DP_OPEN]) begin
                dprot_r[flash_prot_pkg::DP_OPEN] <= 1'b0;
            end
        end
    end


    // protection check against the value in force
    // open bit set means the size field is ignored entirely
    // block erase is refused whenever any sector is covered
    // the compare is combinational; the refusal is registered below
    logic dp_hit;
    logic dp_any;
    logic bad_op;
    always_comb begin
        dp_any = !dprot_r[flash_prot_pkg::DP_OPEN];
        dp_hit = dp_any && chk_in.addr >= flash_prot_pkg::DF_BASE && chk_in.addr < df_end(dprot_r[4:0]);
        bad_op = 1'b0;
        unique case (chk_in.kind)
            flash_prot_pkg::OP_NONE: bad_op = 1'b0;
            flash_prot_pkg::OP_PROGRAM: bad_op = dp_hit;
            flash_prot_pkg::OP_SECT_ERASE: bad_op = dp_hit;
            flash_prot_pkg::OP_BLOCK_ERASE: bad_op = dp_any;
        endcase
    end


    // launch: a one written to the complete flag while idle
    // a launch write while busy is lost, not queued
    logic launch_wr;
    assign launch_wr = req_in.wr && req_in.addr == flash_prot_pkg::OFS_STAT && command_complete_flag_r && req_in.wdata[flash_prot_pkg::ST_COMMAND_COMPLETE_FLAG];


    // command complete flag: software clears by writing one, engine sets on done
    // done and a launch never take effect in one cycle: done only counts while busy, a launch only while idle
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            command_complete_flag_r <= 1'b1;
        end else if (done_in && !command_complete_flag_r) begin
            command_complete_flag_r <= 1'b1;
        end else if (launch_wr) begin
            command_complete_flag_r <= 1'b0;
        end
    end


    // busy mirror of the complete flag, its own flop so the port has no gate after it
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            busy_r <= 1'b0;
        end else if (done_in && !command_complete_flag_r) begin
            busy_r <= 1'b0;
        end else if (launch_wr) begin
            busy_r <= 1'b1;
        end
    end

    // violation flag: set wins over a same-cycle software clear
    // a clear is honoured in any state; only the set needs a busy cycle
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            pviol_r <= 1'b0;
        end else if (!command_complete_flag_r && bad_op) begin
            pviol_r <= 1'b1;
        end else if (req_in.wr && req_in.addr == flash_prot_pkg::OFS_STAT && req_in.wdata[flash_prot_pkg::ST_PVIOL]) begin
            pviol_r <= 1'b0;
        end
    end


    // engine strobes
    // refusal repeats every busy cycle the request stays protected
    // so the engine may sample it whenever it likes
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            launch_r <= 1'b0;
            refuse_r <= 1'b0;
        end else begin
            launch_r <= launch_wr;
            refuse_r <= !command_complete_flag_r && bad_op;
        end
    end


    // index register
    // not locked: software may point at results while a command runs
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            cidx_r <= 3'h0;
        end else if (req_in.wr && req_in.addr == flash_prot_pkg::OFS_CIDX) begin
            cidx_r <= req_in.wdata[2:0];
        end
    end


    // command object array: byte or word writes, locked while busy, results from engine
    // engine results only land while busy, software writes only while idle
    // so the two writers can never collide on one word
    // bit seven of word zero low byte is forced zero on every software write that reaches the low byte
    logic cob_we_hi;
    logic cob_we_lo;
    always_comb begin
        cob_we_hi = req_in.wr && command_complete_flag_r && cidx_r <= flash_prot_pkg::COB_LAST &&
                    (req_in.addr == flash_prot_pkg::OFS_COBJ_HI || req_in.addr == flash_prot_pkg::OFS_COBJ_W);
        cob_we_lo = req_in.wr && command_complete_flag_r && cidx_r <= flash_prot_pkg::COB_LAST &&
                    (req_in.addr == flash_prot_pkg::OFS_COBJ_LO || req_in.addr == flash_prot_pkg::OFS_COBJ_W);
    end
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < flash_prot_pkg::COB_WORDS; i++) begin
                cob_r[i] <= 16'h0000;
            end
        end else if (!command_complete_flag_r) begin
            if (res_we_in && res_idx_in <= flash_prot_pkg::COB_LAST) begin
                cob_r[res_idx_in] <= res_data_in;
            end
        end else begin
            if (cob_we_hi) begin
                cob_r[cidx_r][15:8] <= (req_in.addr == flash_prot_pkg::OFS_COBJ_W) ? req_in.wdata[15:8] : wb;
            end
            if (cob_we_lo) begin
                cob_r[cidx_r][7:0] <= wb & ((cidx_r == 3'h0) ? flash_prot_pkg::COB_IDX0_MASK[7:0] : 8'hff);
            end
        end
    end


    // read data one cycle after the strobe
    // read data return to zero in cycles without a read strobe
    // unmapped offsets and the reserved register read as zero
    logic [15:0] cob_sel;
    logic [15:0] rd_nxt;
    always_comb begin
        cob_sel = (cidx_r <= flash_prot_pkg::COB_LAST) ? cob_r[cidx_r] : 16'h0000;
        rd_nxt = 16'h0000;
        unique case (req_in.addr)
            flash_prot_pkg::OFS_PPROT: rd_nxt = {8'h00, pprot_r};
            flash_prot_pkg::OFS_DPROT: rd_nxt = {8'h00, dprot_r};
            flash_prot_pkg::OFS_CIDX: rd_nxt = {13'h0000, cidx_r};
            flash_prot_pkg::OFS_COBJ_HI: rd_nxt = {8'h00, cob_sel[15:8]};
            flash_prot_pkg::OFS_COBJ_LO: rd_nxt = {8'h00, cob_sel[7:0]};
            flash_prot_pkg::OFS_COBJ_W: rd_nxt = cob_sel;
            flash_prot_pkg::OFS_STAT: rd_nxt = {8'h00, command_complete_flag_r, 2'b00, pviol_r, 4'h0};
            flash_prot_pkg::OFS_RSV0: rd_nxt = 16'h0000;
            default: rd_nxt = 16'h0000;
        endcase
    end
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= req_in.rd ? rd_nxt : 16'h0000;
        end
    end


    // every output comes straight from a flop
    assign rdata_out = rdata_r;
    assign launch_out = launch_r;
    assign refuse_out = refuse_r;
    assign busy_out = busy_r;
    assign cob_word0_out = cob_r[0];
    assign cob_word1_out = cob_r[1];
endmodule : flash_prot_cob
`default_nettype wire

// ==== rtl/flash_prot_pkg.sv ====
// package: register map, field layout and constants of the flash protection and command object block
package flash_prot_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] OFS_PPROT = 4'h0;
    localparam logic [3:0] OFS_DPROT = 4'h1;
    localparam logic [3:0] OFS_CIDX = 4'h2;
    localparam logic [3:0] OFS_COBJ_HI = 4'h3;
    localparam logic [3:0] OFS_COBJ_LO = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h5;
    localparam logic [3:0] OFS_RSV0 = 4'h6;
    localparam logic [3:0] OFS_COBJ_W = 4'h7;
    // program flash protection field positions
    localparam int PP_OPEN = 7;
    localparam int PP_HDIS = 5;
    localparam int PP_LDIS = 2;
    localparam int PP_HS_LSB = 3;
    localparam int PP_LS_LSB = 0;
    localparam logic [7:0] PP_WMASK = 8'hbf;
    // data flash protection fields
    localparam int DP_OPEN = 7;
    localparam logic [4:0] DP_SIZE_FULL = 5'h1f;
    localparam logic [7:0] DP_WMASK = 8'h9f;
    // status bits
    localparam int ST_COMMAND_COMPLETE_FLAG = 7;
    localparam int ST_PVIOL = 4;
    // command object geometry
    localparam int COB_WORDS = 6;
    localparam logic [2:0] COB_LAST = 3'h5;
    localparam logic [15:0] COB_IDX0_MASK = 16'hff7f;
    // data flash protection window
    localparam logic [22:0] DF_BASE = 23'h10_0000;
    localparam int DF_SECT_SHIFT = 8;
    // flash operation kinds requested by the command engine
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_SECT_ERASE = 2'h2,
        OP_BLOCK_ERASE = 2'h3
    } op_kind_t;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // protection check request from the command engine
    typedef struct packed {
        op_kind_t kind;
        logic [22:0] addr;
    } chk_req_t;
endpackage : flash_prot_pkg

// ==== dv/flash_prot_cob_properties.sv ====
// checker: port-level properties of the flash protection and command object block
`timescale 1ns/1ps
`default_nettype none
module flash_prot_cob_properties (
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // register port
    input wire flash_prot_pkg::reg_req_t req_in,
    input wire logic [15:0] rdata_out,
    // command engine side
    input wire flash_prot_pkg::chk_req_t chk_in,
    input wire logic done_in,
    input wire logic res_we_in,
    input wire logic [2:0] res_idx_in,
    input wire logic [15:0] res_data_in,
    input wire logic launch_out,
    input wire logic refuse_out,
    input wire logic busy_out,
    input wire logic [15:0] cob_word0_out,
    input wire logic [15:0] cob_word1_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // software launch write, seen on the port
    logic launch_req;
    assign launch_req = req_in.wr && req_in.addr == flash_prot_pkg::OFS_STAT && req_in.wdata[7];
    AST_RSV_ZERO: assert property (
        req_in.rd && req_in.addr == flash_prot_pkg::OFS_RSV0 |=> rdata_out == 16'h0000)
        else $error("reserved register read not zero");
    AST_LAUNCH: assert property (
        !busy_out && launch_req |=> busy_out && launch_out)
        else $error("launch write did not start a command");
    AST_IDLE_HOLDS: assert property (
        !busy_out && !launch_req |=> !busy_out && !launch_out)
        else $error("command started without a launch write");
    // engine result writes are the only way the words move while busy
    AST_LOCK: assert property (
        busy_out && !res_we_in |=> $stable(cob_word0_out) && $stable(cob_word1_out))
        else $error("command object changed while locked");
    AST_DONE: assert property (
        busy_out && done_in |=> !busy_out)
        else $error("completion did not set the complete flag");
    AST_RESULT: assert property (
        busy_out && res_we_in && res_idx_in == 3'h1 |=> cob_word1_out == $past(res_data_in))
        else $error("result word not stored");
    AST_REFUSE_CAUSE: assert property (
        refuse_out |-> $past(busy_out) && $past(chk_in.kind) != flash_prot_pkg::OP_NONE)
        else $error("refusal without a busy operation");
    AST_IDX0_BIT: assert property (
        cob_word0_out[7] == 1'b0)
        else $error("word zero bit seven not zero");
endmodule : flash_prot_cob_properties
bind flash_prot_cob flash_prot_cob_properties props (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(req_in),
    .rdata_out(rdata_out), .chk_in(chk_in), .done_in(done_in), .res_we_in(res_we_in), .res_idx_in(res_idx_in),
    .res_data_in(res_data_in), .launch_out(launch_out), .refuse_out(refuse_out), .busy_out(busy_out),
    .cob_word0_out(cob_word0_out), .cob_word1_out(cob_word1_out));
`default_nettype wire

// ==== dv/test_flash_prot_cob.sv ====
// testbench: register port sequences for the flash protection and command object block
`timescale 1ns/1ps
`default_nettype none
module test_flash_prot_cob;
    // design signals
    logic clock_in, rstn_in, dbl, done, res_we, launch, refuse, busy;
    logic [2:0] res_idx;
    logic [3:0] a;
    logic [15:0] res_data, rdata, w0, w1;
    flash_prot_pkg::reg_req_t req;
    flash_prot_pkg::chk_req_t chk;
    int n_mismatch = 0;
    int n_compared = 0;
    // written value then value read back: eight pflash pairs, five dflash pairs
    logic [7:0] seq [26] = '{8'hbb, 8'hbb, 8'hbf, 8'hbb, 8'h9f, 8'hbb, 8'h9b, 8'h9b, 8'h98, 8'h9b, 8'h93, 8'h9b,
        8'h3f, 8'h3f, 8'hbf, 8'h3f, 8'h83, 8'h85, 8'h86, 8'h86, 8'h06, 8'h06, 8'h86, 8'h06, 8'h05, 8'h06};
    // config bytes fixed: scenario 7, data flash open with size 5
    flash_prot_cob uut (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
        .cfg_pprot_in(8'hff), .cfg_dprot_in(8'h85), .cfg_dbl_fault_in(dbl), .chk_in(chk), .done_in(done),
        .res_we_in(res_we), .res_idx_in(res_idx), .res_data_in(res_data), .launch_out(launch),
        .refuse_out(refuse), .busy_out(busy), .cob_word0_out(w0), .cob_word1_out(w1));
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clock_in) req <= '{ad, d, 1'b1, 1'b0};
        @(posedge clock_in) req <= '0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] ad, input logic [15:0] exp);
        @(posedge clock_in) req <= '{ad, 16'h0000, 1'b0, 1'b1};
        @(posedge clock_in) req <= '0;
        #1 check("rdata", rdata, exp);
    endtask : rd
    task automatic rst(input logic f);
        rstn_in <= 1'b0;
        dbl <= f;
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
    endtask : rst
    // check request driven and left in place; refusal registered after one busy cycle
    task automatic probe(input flash_prot_pkg::op_kind_t k, input logic [22:0] ad, input logic exp);
        @(posedge clock_in) chk <= '{k, ad};
        @(posedge clock_in);
        #1 check("refuse", {15'h0000, refuse}, {15'h0000, exp});
    endtask : probe
    task automatic finish_cmd();
        @(posedge clock_in) done <= 1'b1;
        @(posedge clock_in) done <= 1'b0;
    endtask : finish_cmd
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {req, chk, done, res_we, res_idx, res_data, rstn_in, dbl} = '0;
        rst(1'b0);
        rd(flash_prot_pkg::OFS_PPROT, 16'h00bf);
        rd(flash_prot_pkg::OFS_DPROT, 16'h0085);
        wr(flash_prot_pkg::OFS_STAT, 16'h0080);
        probe(flash_prot_pkg::OP_BLOCK_ERASE, 23'h10_0000, 1'b0);
        probe(flash_prot_pkg::OP_PROGRAM, 23'h10_0000, 1'b0);
        finish_cmd();
        for (int i = 0; i < 13; i++) begin
            a = (i < 8) ? flash_prot_pkg::OFS_PPROT : flash_prot_pkg::OFS_DPROT;
            wr(a, {8'h00, seq[2*i]});
            rd(a, {8'h00, seq[2*i+1]});
        end
        wr(flash_prot_pkg::OFS_CIDX, 16'h0000);
        wr(flash_prot_pkg::OFS_COBJ_W, 16'habff);
        rd(flash_prot_pkg::OFS_COBJ_W, 16'hab7f);
        check("word0", w0, 16'hab7f);
        wr(flash_prot_pkg::OFS_CIDX, 16'h0001);
        wr(flash_prot_pkg::OFS_COBJ_W, 16'h1234);
        wr(flash_prot_pkg::OFS_COBJ_LO, 16'h5656);
        wr(flash_prot_pkg::OFS_COBJ_HI, 16'h7878);
        rd(flash_prot_pkg::OFS_COBJ_W, 16'h7856);
        wr(flash_prot_pkg::OFS_CIDX, 16'h0006);
        wr(flash_prot_pkg::OFS_COBJ_W, 16'hffff);
        rd(flash_prot_pkg::OFS_COBJ_W, 16'h0000);
        wr(flash_prot_pkg::OFS_CIDX, 16'h0001);
        wr(flash_prot_pkg::OFS_STAT, 16'h0080);
        #1 check("busy", {15'h0000, busy}, 16'h0001);
        wr(flash_prot_pkg::OFS_COBJ_W, 16'h5555);
        wr(flash_prot_pkg::OFS_DPROT, 16'h0007);
        #1 check("word1", w1, 16'h7856);
        probe(flash_prot_pkg::OP_PROGRAM, 23'h10_06ff, 1'b1);
        probe(flash_prot_pkg::OP_PROGRAM, 23'h10_0700, 1'b0);
        probe(flash_prot_pkg::OP_PROGRAM, 23'h0f_ffff, 1'b0);
        probe(flash_prot_pkg::OP_SECT_ERASE, 23'h10_0000, 1'b1);
        probe(flash_prot_pkg::OP_BLOCK_ERASE, 23'h10_0700, 1'b1);
        rd(flash_prot_pkg::OFS_STAT, 16'h0010);
        @(posedge clock_in) {res_we, res_idx, res_data} <= {1'b1, 3'h1, 16'hbeef};
        @(posedge clock_in) res_we <= 1'b0;
        finish_cmd();
        rd(flash_prot_pkg::OFS_COBJ_W, 16'hbeef);
        rd(flash_prot_pkg::OFS_DPROT, 16'h0006);
        rd(flash_prot_pkg::OFS_STAT, 16'h0090);
        wr(flash_prot_pkg::OFS_STAT, 16'h0010);
        rd(flash_prot_pkg::OFS_STAT, 16'h0080);
        wr(flash_prot_pkg::OFS_RSV0, 16'hffff);
        rd(flash_prot_pkg::OFS_RSV0, 16'h0000);
        rd(4'h8, 16'h0000);
        rst(1'b1);
        rd(flash_prot_pkg::OFS_DPROT, 16'h001f);
        report_and_stop();
    end
endmodule : test_flash_prot_cob
`default_nettype wire
